// file: rtl/ofm_menu.sv
// Purpose: three-button menu that picks and stores the output functions
// Assumes: button inputs are synchronous to clock and active high
// Notes:   stored configuration only changes on a left press that commits
`timescale 1ns/1ps

module ofm_menu #(
    parameter int TICK_CYCLES = ofm_pkg::TICK_CYC,
    parameter int TIMEOUT_MS  = ofm_pkg::TIMEOUT_MS,
    parameter int OUT_HOLD_MS = ofm_pkg::OUT_HOLD_MS,
    parameter int DEBOUNCE_MS = ofm_pkg::DEBOUNCE_MS
) (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               reset,
    // front panel buttons: left, middle, right
    input  wire logic [2:0]         buttons,
    // measurement side
    input  wire logic               ctrl1_on,
    input  wire logic               ctrl2_on,
    input  wire logic               alarm1,
    input  wire logic               alarm2,
    input  wire logic               fault,
    // menu view
    output ofm_pkg::ofm_state_t     menu_state,
    output logic                    sp_menu_open,
    output ofm_pkg::ofm_cfg_t       cfg_stored,
    output ofm_pkg::ofm_cfg_t       cfg_edit,
    // switching outputs
    output ofm_pkg::ofm_pin_t       pin1,
    output ofm_pkg::ofm_pin_t       pin2
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] wrap_step(input logic [7:0] v, input logic [7:0] lo,
                                             input logic [7:0] hi, input logic up);
        if (up)
            wrap_step = (v >= hi) ? lo : 8'(v + 8'h01);
        else
            wrap_step = (v <= lo) ? hi : 8'(v - 8'h01);
    endfunction

    function automatic ofm_pkg::ofm_pin_t drive(input logic on, input ofm_pkg::ofm_drive_t k);
        drive.source_on = on && (k != ofm_pkg::LOW_SIDE_SINK);
        drive.sink_on   = (k == ofm_pkg::LOW_SIDE_SINK) ? on
                        : (k == ofm_pkg::PUSH_PULL_DRIVE) ? !on : 1'b0;
    endfunction

    // next parameter after s, skipping what the function does not use
    function automatic ofm_pkg::ofm_state_t next_param(input ofm_pkg::ofm_state_t s,
                                                        input ofm_pkg::ofm_func_t f);
        logic ctl1;
        logic ctl2;
        logic alm;
        ctl1 = (f == ofm_pkg::SINGLE_TWO_POINT_CTRL) || (f == ofm_pkg::DUAL_TWO_POINT_CTRL)
            || (f == ofm_pkg::TWO_POINT_WITH_ALARM);
        ctl2 = (f == ofm_pkg::DUAL_TWO_POINT_CTRL);
        alm  = (f == ofm_pkg::TWO_POINT_WITH_ALARM) || (f == ofm_pkg::ALARM_COMMON)
            || (f == ofm_pkg::ALARM_INDIVIDUAL);
        case (s)
            ofm_pkg::M_FUNC: next_param = ctl1 ? ofm_pkg::M_D1 : alm ? ofm_pkg::M_AK
                                        : ofm_pkg::M_IDLE;
            ofm_pkg::M_D1:   next_param = ofm_pkg::M_K1;
            ofm_pkg::M_K1:   next_param = ofm_pkg::M_E1;
            ofm_pkg::M_E1:   next_param = ctl2 ? ofm_pkg::M_D2 : alm ? ofm_pkg::M_AK
                                        : ofm_pkg::M_IDLE;
            ofm_pkg::M_D2:   next_param = ofm_pkg::M_K2;
            ofm_pkg::M_K2:   next_param = ofm_pkg::M_E2;
            ofm_pkg::M_E2:   next_param = ofm_pkg::M_IDLE;
            default:         next_param = ofm_pkg::M_IDLE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // millisecond tick and debounce
    // ------------------------------------------------------------
    logic [31:0] tick_cnt_reg;
    logic        tick_reg;
    logic [2:0]  btn_reg;
    logic [2:0]  btn_prev_reg;
    logic [7:0]  deb_cnt_reg [3];
    logic [15:0] hold_reg [3];

    always_ff @(posedge clock) begin
        if (reset || tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
        end
        tick_reg <= !reset && tick_cnt_reg == 32'(TICK_CYCLES - 1);
    end

    always_ff @(posedge clock) begin
        btn_prev_reg <= reset ? 3'h0 : btn_reg;
        for (int i = 0; i < 3; i++) begin
            if (reset) begin
                btn_reg[i]     <= 1'b0;
                deb_cnt_reg[i] <= '0;
                hold_reg[i]    <= '0;
            end else begin
                if (buttons[i] == btn_reg[i]) begin
                    deb_cnt_reg[i] <= '0;
                end else if (tick_reg) begin
                    if (deb_cnt_reg[i] == 8'(DEBOUNCE_MS - 1)) begin
                        btn_reg[i]     <= buttons[i];
                        deb_cnt_reg[i] <= '0;
                    end else begin
                        deb_cnt_reg[i] <= deb_cnt_reg[i] + 8'h01;
                    end
                end
                // saturating hold time in ms
                if (!btn_reg[i])
                    hold_reg[i] <= '0;
                else if (tick_reg && hold_reg[i] != 16'hffff)
                    hold_reg[i] <= hold_reg[i] + 16'h0001;
            end
        end
    end

    logic [2:0] pressed;
    logic [2:0] released;
    assign pressed  = btn_reg & ~btn_prev_reg;
    assign released = ~btn_reg & btn_prev_reg;

    // ------------------------------------------------------------
    // button events
    // ------------------------------------------------------------
    ofm_pkg::ofm_state_t state_reg;
    ofm_pkg::ofm_cfg_t   cfg_reg;
    ofm_pkg::ofm_cfg_t   work_reg;
    logic                lock_reg;
    logic [15:0]         rep_cnt_reg;
    logic [31:0]         idle_reg;
    logic                hold_out;
    logic                hold_sp;
    logic                left_short;
    logic                rep_hit;
    logic                step_up;
    logic                step_dn;
    logic                timeout;
    logic [15:0]         rep_hold;

    // a hold event fires once: hold_out on the tick that reaches OUT_HOLD_MS, hold_sp on the tick that passes SP_HOLD_MS
    assign hold_out   = tick_reg && btn_reg[ofm_pkg::BTN_MID]
                     && hold_reg[ofm_pkg::BTN_MID] == 16'(OUT_HOLD_MS - 1);
    assign hold_sp    = tick_reg && btn_reg[ofm_pkg::BTN_LEFT]
                     && hold_reg[ofm_pkg::BTN_LEFT] == 16'(ofm_pkg::SP_HOLD_MS);
    assign left_short = released[ofm_pkg::BTN_LEFT] && !lock_reg
                     && hold_reg[ofm_pkg::BTN_LEFT] <= 16'(ofm_pkg::SP_HOLD_MS);
    assign rep_hold   = btn_reg[ofm_pkg::BTN_MID] ? hold_reg[ofm_pkg::BTN_MID]
                                                  : hold_reg[ofm_pkg::BTN_RIGHT];
    assign rep_hit    = tick_reg && rep_hold > 16'(ofm_pkg::REPEAT_MS)
                     && rep_cnt_reg == ((rep_hold > 16'(ofm_pkg::REPEAT_MS
                                         + ofm_pkg::FAST_AFTER_MS))
                                        ? 16'(ofm_pkg::FAST_RATE_MS - 1)
                                        : 16'(ofm_pkg::SLOW_RATE_MS - 1));
    assign step_up    = !lock_reg && btn_reg[ofm_pkg::BTN_MID] && !btn_reg[ofm_pkg::BTN_RIGHT]
                     && (pressed[ofm_pkg::BTN_MID] || rep_hit);
    assign step_dn    = !lock_reg && btn_reg[ofm_pkg::BTN_RIGHT] && !btn_reg[ofm_pkg::BTN_MID]
                     && (pressed[ofm_pkg::BTN_RIGHT] || rep_hit);
    assign timeout    = tick_reg && idle_reg == 32'(TIMEOUT_MS);

    // repeat interval counter restarts with every press
    always_ff @(posedge clock) begin
        if (reset || pressed != 3'h0 || rep_hit || rep_hold <= 16'(ofm_pkg::REPEAT_MS))
            rep_cnt_reg <= '0;
        else if (tick_reg)
            rep_cnt_reg <= rep_cnt_reg + 16'h0001;
    end

    // inactivity: a held button counts as pressed, so long auto-repeat never aborts
    always_ff @(posedge clock) begin
        if (reset || btn_reg != 3'h0 || state_reg == ofm_pkg::M_IDLE)
            idle_reg <= '0;
        else if (tick_reg)
            idle_reg <= idle_reg + 32'h1;
    end

    // a press that opened a menu must not also edit it
    always_ff @(posedge clock) begin
        if (reset)
            lock_reg <= 1'b0;
        else if (hold_out || hold_sp)
            lock_reg <= 1'b1;
        else if (btn_reg == 3'h0 && released == 3'h0)
            lock_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // menu walk
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= ofm_pkg::M_IDLE;
        end else if (timeout) begin
            state_reg <= ofm_pkg::M_IDLE;
        end else begin
            case (state_reg)
                ofm_pkg::M_IDLE: begin
                    if (hold_out)
                        state_reg <= ofm_pkg::M_FUNC;
                    else if (hold_sp && cfg_reg.func != ofm_pkg::FUNC_NONE)
                        state_reg <= ofm_pkg::M_SP;
                end
                ofm_pkg::M_SP: begin
                    if (left_short)
                        state_reg <= ofm_pkg::M_IDLE;
                end
                default: begin
                    // left advances only from a label not being edited
                    if (left_short && work_reg == cfg_reg)
                        state_reg <= next_param(state_reg, cfg_reg.func);
                end
            endcase
        end
    end

    // working copy: edited by steps, dropped on timeout
    always_ff @(posedge clock) begin
        if (reset) begin
            work_reg <= ofm_pkg::CFG_RESET;
        end else if (state_reg == ofm_pkg::M_IDLE || timeout) begin
            work_reg <= cfg_reg;
        end else if (step_up || step_dn) begin
            case (state_reg)
                ofm_pkg::M_FUNC: work_reg.func <= ofm_pkg::ofm_func_t'(3'(wrap_step(
                    8'(work_reg.func), 8'h00, ofm_pkg::FUNC_MAX, step_up)));
                ofm_pkg::M_D1: work_reg.out1_delay <= wrap_step(work_reg.out1_delay,
                    ofm_pkg::DELAY_MIN, ofm_pkg::DELAY_MAX, step_up);
                ofm_pkg::M_K1: work_reg.kind1 <= ofm_pkg::ofm_drive_t'(2'(wrap_step(
                    8'(work_reg.kind1), 8'h00, ofm_pkg::DRIVE_MAX, step_up)));
                ofm_pkg::M_E1: work_reg.err1 <= !work_reg.err1;
                ofm_pkg::M_D2: work_reg.out2_delay <= wrap_step(work_reg.out2_delay,
                    ofm_pkg::DELAY_MIN, ofm_pkg::DELAY_MAX, step_up);
                ofm_pkg::M_K2: work_reg.kind2 <= ofm_pkg::ofm_drive_t'(2'(wrap_step(
                    8'(work_reg.kind2), 8'h00, ofm_pkg::DRIVE_MAX, step_up)));
                ofm_pkg::M_E2: work_reg.err2 <= !work_reg.err2;
                ofm_pkg::M_AK: work_reg.alarm_kind <= ofm_pkg::ofm_drive_t'(2'(wrap_step(
                    8'(work_reg.alarm_kind), 8'h00, ofm_pkg::DRIVE_MAX, step_up)));
                default: work_reg <= work_reg;
            endcase
        end
    end

    // stored configuration: a left press commits the whole edited value
    always_ff @(posedge clock) begin
        if (reset)
            cfg_reg <= ofm_pkg::CFG_RESET;
        else if (left_short && !timeout && state_reg != ofm_pkg::M_IDLE
                 && state_reg != ofm_pkg::M_SP)
            cfg_reg <= work_reg;
    end

    // ------------------------------------------------------------
    // switching outputs
    // ------------------------------------------------------------
    logic               on1;
    logic               on2;
    logic               alm1;
    logic               alm2;
    ofm_pkg::ofm_drive_t k1;
    ofm_pkg::ofm_drive_t k2;

    assign alm1 = cfg_reg.func == ofm_pkg::ALARM_INDIVIDUAL;
    assign alm2 = cfg_reg.func == ofm_pkg::TWO_POINT_WITH_ALARM
               || cfg_reg.func == ofm_pkg::ALARM_COMMON || alm1;
    // fault overrides; alarm outputs are active while no alarm exists
    assign on1 = fault ? cfg_reg.err1 : alm1 ? !alarm1
               : (cfg_reg.func != ofm_pkg::FUNC_NONE && cfg_reg.func != ofm_pkg::ALARM_COMMON
                  && ctrl1_on);
    assign on2 = fault ? cfg_reg.err2 : alm2 ? !alarm2
               : (cfg_reg.func == ofm_pkg::DUAL_TWO_POINT_CTRL && ctrl2_on);
    assign k1  = alm1 ? cfg_reg.alarm_kind : cfg_reg.kind1;
    assign k2  = alm2 ? cfg_reg.alarm_kind : cfg_reg.kind2;

    always_ff @(posedge clock) begin
        if (reset) begin
            pin1 <= '0;
            pin2 <= '0;
        end else begin
            pin1 <= drive(on1, k1);
            pin2 <= drive(on2, k2);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            menu_state   <= ofm_pkg::M_IDLE;
            sp_menu_open <= 1'b0;
            cfg_stored   <= ofm_pkg::CFG_RESET;
            cfg_edit     <= ofm_pkg::CFG_RESET;
        end else begin
            menu_state   <= state_reg;
            sp_menu_open <= state_reg == ofm_pkg::M_SP;
            cfg_stored   <= cfg_reg;
            cfg_edit     <= work_reg;
        end
    end

endmodule

// file: rtl/ofm_pkg.sv
// Purpose: shared types and constants of the output-function menu
// Assumes: 50 MHz system clock, millisecond tick derived from it
// Notes:   times are in milliseconds; cycle counts are derived here
package ofm_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 50_000_000;
    localparam int TICK_MS       = 1;
    localparam int TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
    localparam int DEBOUNCE_MS   = 20;
    localparam int OUT_HOLD_MS   = 5000;
    localparam int SP_HOLD_MS    = 2000;
    localparam int REPEAT_MS     = 1000;
    localparam int FAST_AFTER_MS = 2000;
    localparam int SLOW_RATE_MS  = 200;
    localparam int FAST_RATE_MS  = 50;
    localparam int TIMEOUT_MS    = 60000;

    // ------------------------------------------------------------
    // value ranges (delay in 10 ms steps: 0.01 .. 2.00 s)
    // ------------------------------------------------------------
    localparam logic [7:0] DELAY_MIN = 8'h01;
    localparam logic [7:0] DELAY_MAX = 8'hc8;
    localparam logic [7:0] FUNC_MAX  = 8'h05;
    localparam logic [7:0] DRIVE_MAX = 8'h02;
    localparam logic [7:0] ERR_MAX   = 8'h01;

    // button indices
    localparam int BTN_LEFT  = 0;
    localparam int BTN_MID   = 1;
    localparam int BTN_RIGHT = 2;

    typedef enum logic [2:0] {
        FUNC_NONE             = 3'h0,
        SINGLE_TWO_POINT_CTRL = 3'h1,
        DUAL_TWO_POINT_CTRL   = 3'h2,
        TWO_POINT_WITH_ALARM  = 3'h3,
        ALARM_COMMON          = 3'h4,
        ALARM_INDIVIDUAL      = 3'h5
    } ofm_func_t;

    typedef enum logic [1:0] {
        LOW_SIDE_SINK    = 2'h0,
        HIGH_SIDE_SOURCE = 2'h1,
        PUSH_PULL_DRIVE  = 2'h2
    } ofm_drive_t;

    // menu position; gray codes along the parameter walk M_FUNC to M_E2
    typedef enum logic [3:0] {
        M_IDLE = 4'h0,
        M_FUNC = 4'h1,
        M_D1   = 4'h3,
        M_K1   = 4'h2,
        M_E1   = 4'h6,
        M_D2   = 4'h7,
        M_K2   = 4'h5,
        M_E2   = 4'h4,
        M_AK   = 4'hc,
        M_SP   = 4'hd
    } ofm_state_t;

    typedef struct packed {
        ofm_func_t  func;
        logic [7:0] out1_delay;
        ofm_drive_t kind1;
        logic       err1;
        logic [7:0] out2_delay;
        ofm_drive_t kind2;
        logic       err2;
        ofm_drive_t alarm_kind;
    } ofm_cfg_t;

    localparam ofm_cfg_t CFG_RESET = '{FUNC_NONE, 8'h01, LOW_SIDE_SINK, 1'b0,
                                       8'h01, LOW_SIDE_SINK, 1'b0, LOW_SIDE_SINK};

    // pin drive of one switching output
    typedef struct packed {
        logic source_on;
        logic sink_on;
    } ofm_pin_t;

endpackage

// file: tb/ofm_menu_asserts.sv
// Purpose: port-level checks of the output-function menu
// Assumes: one clock domain, synchronous active-high reset
// Notes:   pin drive is judged one cycle after its cause
`timescale 1ns/1ps
module ofm_menu_asserts (
    // clock and reset
    input wire logic                clock,
    input wire logic                reset,
    // measurement side
    input wire logic                ctrl1_on,
    input wire logic                alarm1,
    input wire logic                alarm2,
    input wire logic                fault,
    // menu and pins
    input wire ofm_pkg::ofm_state_t menu_state,
    input wire logic                sp_menu_open,
    input wire ofm_pkg::ofm_cfg_t   cfg_stored,
    input wire ofm_pkg::ofm_cfg_t   cfg_edit,
    input wire ofm_pkg::ofm_pin_t   pin1,
    input wire ofm_pkg::ofm_pin_t   pin2
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // previous edited delay, to judge single steps and wrap
    logic [7:0] d_prev;
    always_ff @(posedge clock) begin
        d_prev <= cfg_edit.out1_delay;
    end
    wire logic up_ok = (cfg_edit.out1_delay == d_prev + 8'h01) ||
                       (d_prev == 8'hc8 && cfg_edit.out1_delay == 8'h01);
    wire logic dn_ok = (cfg_edit.out1_delay == d_prev - 8'h01) ||
                       (d_prev == 8'h01 && cfg_edit.out1_delay == 8'hc8);

    sequence s_d1_step;
        menu_state == ofm_pkg::M_D1
        ##1 menu_state == ofm_pkg::M_D1 && cfg_edit.out1_delay != d_prev;
    endsequence

    a_d1_step: assert property (s_d1_step |-> up_ok || dn_ok)
        else $error("delay edit moved by more than one step");
    a_edit_range: assert property (cfg_edit.out1_delay inside {[8'h01:8'hc8]}
        && cfg_edit.kind1 != 2'h3 && cfg_edit.func <= 3'h5)
        else $error("edited value outside its range");
    a_sink_ctrl: assert property (cfg_stored.func == ofm_pkg::TWO_POINT_WITH_ALARM
        && cfg_stored.kind1 == ofm_pkg::LOW_SIDE_SINK
        |-> pin1 == {1'b0, ($past(fault) ? cfg_stored.err1 : $past(ctrl1_on))})
        else $error("output 1 sink drive wrong");
    a_pp_comp: assert property (cfg_stored.kind1 == ofm_pkg::PUSH_PULL_DRIVE
        && cfg_stored.func inside {3'h1, 3'h2, 3'h3} |-> pin1.source_on != pin1.sink_on)
        else $error("push-pull halves not complementary");
    a_alarm_inv: assert property (cfg_stored.func == ofm_pkg::ALARM_COMMON
        && cfg_stored.alarm_kind == ofm_pkg::PUSH_PULL_DRIVE && !$past(fault)
        |-> pin2 == {!$past(alarm2), $past(alarm2)})
        else $error("alarm output not inverted");
    a_indiv_both: assert property (cfg_stored.func == ofm_pkg::ALARM_INDIVIDUAL
        && cfg_stored.alarm_kind == ofm_pkg::LOW_SIDE_SINK && !$past(fault)
        |-> pin1 == {1'b0, !$past(alarm1)} && pin2 == {1'b0, !$past(alarm2)})
        else $error("alarm drive not shared by both outputs");
    a_sp_func: assert property (sp_menu_open |-> cfg_stored.func != ofm_pkg::FUNC_NONE)
        else $error("switchpoint menu open without outputs");
    a_out2_dual: assert property (menu_state inside {ofm_pkg::M_D2, ofm_pkg::M_K2,
        ofm_pkg::M_E2} |-> cfg_stored.func == ofm_pkg::DUAL_TWO_POINT_CTRL)
        else $error("output 2 settings shown without dual control");
    a_ak_alarm: assert property (menu_state == ofm_pkg::M_AK
        |-> cfg_stored.func inside {3'h3, 3'h4, 3'h5})
        else $error("alarm drive shown without alarm");
    a_out1_ctrl: assert property (menu_state inside {ofm_pkg::M_D1, ofm_pkg::M_K1,
        ofm_pkg::M_E1} |-> cfg_stored.func inside {3'h1, 3'h2, 3'h3})
        else $error("output 1 settings shown without controller");
endmodule

// file: tb/ofm_operator.sv
// Purpose: operator at the front panel pressing the three buttons
// Assumes: buttons read high while pressed
// Notes:   each press ends with a settle gap longer than the debounce
`timescale 1ns/1ps
module ofm_operator #(
    parameter int TICK_CYCLES = 4
) (
    // clock
    input wire logic       clock,
    // front panel
    output logic     [2:0] buttons
);
    initial buttons = 3'h0;

    task automatic press(input int idx, input int ms);
        @(posedge clock) #1 buttons[idx] = 1'b1;
        repeat (ms * TICK_CYCLES) @(posedge clock);
        #1 buttons[idx] = 1'b0;
        repeat (5 * TICK_CYCLES) @(posedge clock);
        #1;
    endtask
endmodule

// file: tb/tb_top.sv
// Purpose: self-checking bench of the output-function menu
// Assumes: tick shortened to 4 cycles, output-menu hold, debounce and timeout scaled
// Notes:   a bench copy of the stored settings predicts every result but the auto-repeat step count, which is checked against a range
`timescale 1ns/1ps
module tb_top;
    // ------------------------------------------------------------
    // design and operator
    // ------------------------------------------------------------
    localparam int TK = 4;
    logic                clock = 1'b0;
    logic                reset;
    logic          [2:0] buttons;
    logic          [4:0] v;
    ofm_pkg::ofm_state_t menu_state;
    logic                sp_menu_open;
    ofm_pkg::ofm_cfg_t   cfg_stored;
    ofm_pkg::ofm_cfg_t   cfg_edit;
    ofm_pkg::ofm_pin_t   pin1;
    ofm_pkg::ofm_pin_t   pin2;
    ofm_pkg::ofm_cfg_t   model;
    int                  d;
    int                  error_cnt = 0;
    int                  checks = 0;

    always #10 clock = ~clock;

    ofm_menu #(.TICK_CYCLES(TK), .TIMEOUT_MS(1500), .OUT_HOLD_MS(20), .DEBOUNCE_MS(2))
        ofm_menu_inst (.clock, .reset, .buttons, .ctrl1_on(v[0]), .ctrl2_on(v[1]),
        .alarm1(v[2]), .alarm2(v[3]), .fault(v[4]),
        .menu_state, .sp_menu_open, .cfg_stored, .cfg_edit, .pin1, .pin2);
    ofm_operator #(.TICK_CYCLES(TK)) ofm_operator_inst (.clock, .buttons);

    // ------------------------------------------------------------
    // expectations
    // ------------------------------------------------------------
    function automatic ofm_pkg::ofm_state_t nxt(ofm_pkg::ofm_state_t s, ofm_pkg::ofm_func_t f);
        case (s)
            ofm_pkg::M_FUNC: return f inside {3'h1, 3'h2, 3'h3} ? ofm_pkg::M_D1
                                    : nxt(ofm_pkg::M_E2, f);
            ofm_pkg::M_D1: return ofm_pkg::M_K1;
            ofm_pkg::M_K1: return ofm_pkg::M_E1;
            ofm_pkg::M_E1: return f == 3'h2 ? ofm_pkg::M_D2 : nxt(ofm_pkg::M_E2, f);
            ofm_pkg::M_D2: return ofm_pkg::M_K2;
            ofm_pkg::M_K2: return ofm_pkg::M_E2;
            ofm_pkg::M_E2: return f inside {3'h3, 3'h4, 3'h5} ? ofm_pkg::M_AK : ofm_pkg::M_IDLE;
            default: return ofm_pkg::M_IDLE;
        endcase
    endfunction

    function automatic logic [7:0] dstep(logic [7:0] x, bit up);
        return up ? (x == 8'hc8 ? 8'h01 : x + 8'h01) : (x == 8'h01 ? 8'hc8 : x - 8'h01);
    endfunction

    function automatic ofm_pkg::ofm_drive_t kstep(ofm_pkg::ofm_drive_t k, bit up);
        return ofm_pkg::ofm_drive_t'(up ? (k == 2'h2 ? 2'h0 : k + 2'h1)
                                        : (k == 2'h0 ? 2'h2 : k - 2'h1));
    endfunction

    function automatic ofm_pkg::ofm_cfg_t apply(ofm_pkg::ofm_cfg_t c, ofm_pkg::ofm_state_t s,
                                                bit up);
        case (s)
            ofm_pkg::M_D1: c.out1_delay = dstep(c.out1_delay, up);
            ofm_pkg::M_D2: c.out2_delay = dstep(c.out2_delay, up);
            ofm_pkg::M_K1: c.kind1 = kstep(c.kind1, up);
            ofm_pkg::M_K2: c.kind2 = kstep(c.kind2, up);
            ofm_pkg::M_AK: c.alarm_kind = kstep(c.alarm_kind, up);
            ofm_pkg::M_E1: c.err1 = !c.err1;
            default: c.err2 = !c.err2;
        endcase
        return c;
    endfunction

    // drive of output o (1 or 2); in = {fault, alarm2, alarm1, ctrl2, ctrl1}
    function automatic logic [1:0] pin_of(ofm_pkg::ofm_cfg_t c, int o, logic [4:0] in);
        logic                al;
        logic                on;
        ofm_pkg::ofm_drive_t k;
        al = o == 2 ? c.func inside {3'h3, 3'h4, 3'h5} : c.func == 3'h5;
        k = al ? c.alarm_kind : (o == 1 ? c.kind1 : c.kind2);
        on = in[4] ? (o == 1 ? c.err1 : c.err2) : (al ? !in[o + 1] : in[o - 1]);
        return k == 2'h0 ? {1'b0, on} : (k == 2'h1 ? {on, 1'b0} : {on, !on});
    endfunction

    // ------------------------------------------------------------
    // bench tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("ERROR %0t: seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic tap(input int b);
        ofm_operator_inst.press(b, 5);
    endtask

    task automatic results();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // open the menu, choose f, then visit every offered setting once
    task automatic walk(input int f);
        ofm_pkg::ofm_state_t st;
        bit                  up;
        ofm_operator_inst.press(1, 30);
        check(32'(menu_state), 32'(ofm_pkg::M_FUNC));
        repeat ((f - int'(model.func) + 6) % 6) tap(1);
        if (int'(model.func) != f) begin
            model.func = ofm_pkg::ofm_func_t'(f);
            tap(0);
            check(32'(cfg_stored), 32'(model));
        end
        st = nxt(ofm_pkg::M_FUNC, model.func);
        tap(0);
        check(32'(menu_state), 32'(st));
        while (st != ofm_pkg::M_IDLE) begin
            up = !(st inside {ofm_pkg::M_D1, ofm_pkg::M_K1});
            tap(up ? 1 : 2);
            model = apply(model, st, up);
            tap(0);
            check(32'(cfg_stored), 32'(model));
            st = nxt(st, model.func);
            tap(0);
            check(32'(menu_state), 32'(st));
        end
    endtask

    task automatic pins();
        for (int i = 0; i < 8; i++) begin
            @(posedge clock) #1 v = 5'($urandom);
            repeat (3) @(posedge clock);
            #1;
            for (int o = 1; o < 3; o++) begin
                if (o == 1 ? model.func inside {3'h1, 3'h2, 3'h3, 3'h5} : model.func > 3'h1)
                    check(32'(o == 1 ? pin1 : pin2), 32'(pin_of(model, o, v)));
            end
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        model = ofm_pkg::CFG_RESET;
        v = 5'h00;
        reset = 1'b1;
        void'($urandom(30371));
        repeat (10) @(posedge clock);
        #1 reset = 1'b0;
        @(posedge clock) #1;
        check(32'(cfg_stored), 32'(model));
        $display("test reset finished");
        for (int f = 0; f < 6; f++) begin
            walk(f);
            pins();
            if (f < 2) begin
                ofm_operator_inst.press(0, 2100);
                check(32'(sp_menu_open), 32'(f != 0));
                tap(0);
                check(32'(menu_state), 32'(ofm_pkg::M_IDLE));
            end
            $display("test walk %0d finished", f);
        end
        ofm_operator_inst.press(1, 30);
        tap(1);
        tap(1);
        model.func = ofm_pkg::SINGLE_TWO_POINT_CTRL;
        tap(0);
        check(32'(cfg_stored), 32'(model));
        tap(0);
        // slow repeat alone gives about 13 steps, with the faster rate about 21
        ofm_operator_inst.press(2, 3500);
        d = int'(model.out1_delay) - int'(cfg_edit.out1_delay);
        check(32'(d > 17 && d < 25), 32'h1);
        model.out1_delay = dstep(model.out1_delay - 8'(d), 1'b1) - 8'h01;
        tap(0);
        check(32'(cfg_stored), 32'(model));
        tap(0);
        tap(1);
        repeat (1600 * TK) @(posedge clock);
        #1;
        check(32'(menu_state), 32'(ofm_pkg::M_IDLE));
        check(32'(cfg_stored), 32'(model));
        $display("test repeat and timeout finished");
        results();
    end

    initial begin
        repeat (60000) @(posedge clock);
        error_cnt++;
        $display("ERROR %0t: watchdog expired", $time);
        results();
    end
endmodule

bind ofm_menu ofm_menu_asserts ofm_menu_asserts_inst (.clock, .reset, .ctrl1_on, .alarm1,
    .alarm2, .fault, .menu_state, .sp_menu_open, .cfg_stored, .cfg_edit, .pin1, .pin2);
